// [include/cpt_defines.svh]
`ifndef CPT_DEFINES_SVH
`define CPT_DEFINES_SVH

// register byte offsets
`define CPT_OFF_CTRL 8'h00
`define CPT_OFF_AI_DIV 8'h04
`define CPT_OFF_AO_DIV 8'h08
`define CPT_OFF_THRESH 8'h0c
`define CPT_OFF_DELAY 8'h10
`define CPT_OFF_DIO_DIR 8'h14
`define CPT_OFF_DIO_OUT 8'h18
`define CPT_OFF_DIO_IN 8'h1c
`define CPT_OFF_STATUS 8'h20

// control register fields
`define CPT_CTRL_AI_EN 0
`define CPT_CTRL_AI_EXT 1
`define CPT_CTRL_AI_MODE_LSB 2
`define CPT_CTRL_AI_MODE_MSB 3
`define CPT_CTRL_AI_ANALOG 4
`define CPT_CTRL_AI_FALL 5
`define CPT_CTRL_AO_EN 8
`define CPT_CTRL_AO_EXT 9
`define CPT_CTRL_AO_WAIT 10
`define CPT_CTRL_AO_FALL 11

// status register fields
`define CPT_STAT_AI_RUN 0
`define CPT_STAT_AO_RUN 1
`define CPT_STAT_AI_ARMED 2
`define CPT_STAT_AI_DONE 3
`define CPT_STAT_AO_ARMED 4

// reset values
`define CPT_CTRL_RST 32'h00000000
`define CPT_AI_DIV_RST 32'h000000c8
`define CPT_AO_DIV_RST 32'h00000021
`define CPT_THRESH_RST 16'h8000
`define CPT_DELAY_RST 32'h00000000

// synchronised pin vector positions
`define CPT_PIN_AI_PACE 0
`define CPT_PIN_AO_CLK 1
`define CPT_PIN_TTL0 2
`define CPT_PIN_TTL1 3
`define CPT_PIN_THR0 4
`define CPT_PIN_THR1 5
`define CPT_PIN_AO_TRG 6
`define CPT_PIN_DIO 7

// timing: clocks and pacing rates
`define CPT_SYS_CLK_MHZ 250
`define CPT_TIMEBASE_MHZ 100
`define CPT_TIMEBASE_HZ 64'd100000000
`define CPT_AI_MAX_RATE_SPS 64'd500000
`define CPT_AI_MIN_RATE_MSPS 64'd24
`define CPT_AO_MAX_RATE_SPS 64'd3030303
`define CPT_AI_MIN_DIV 32'(`CPT_TIMEBASE_HZ / `CPT_AI_MAX_RATE_SPS)
`define CPT_AI_MAX_DIV 32'((`CPT_TIMEBASE_HZ * 64'd1000) / `CPT_AI_MIN_RATE_MSPS)
`define CPT_AO_MIN_DIV 32'(`CPT_TIMEBASE_HZ / `CPT_AO_MAX_RATE_SPS)

`endif

// [include/cpt_pkg.sv]
package cpt_pkg;

    typedef enum logic [1:0] {
        CPT_TRG_START,
        CPT_TRG_DELAY_START,
        CPT_TRG_STOP,
        CPT_TRG_DELAY_STOP
    } cpt_trig_mode_e;

    typedef enum logic [2:0] {
        AI_IDLE,
        AI_ARMED,
        AI_PRE_DELAY,
        AI_RUN,
        AI_POST_DELAY,
        AI_DONE
    } cpt_ai_state_e;

    typedef enum logic [1:0] {
        AO_IDLE,
        AO_ARMED,
        AO_RUN
    } cpt_ao_state_e;

endpackage

// [include/cpt_pace_if.sv]
`timescale 1ns/1ps
interface cpt_pace_if;
    logic ce;
    logic tick;
    logic enable;
    logic [31:0] divisor;
    logic pulse;
    modport div (input ce, input tick, input enable, input divisor, output pulse);
    modport ctl (output ce, output tick, output enable, output divisor, input pulse);
endinterface // cpt_pace_if

// [verilog/cpt_divider.sv]
`timescale 1ns/1ps
module cpt_divider (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // divider control and output
    cpt_pace_if.div p
);
    logic [31:0] cnt;
    logic pulse;

    assign p.pulse = pulse;

    // counts time-base ticks, reloads at terminal count
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 32'h00000000;
            pulse <= 1'b0;
        end else if (p.ce) begin
            pulse <= p.enable && p.tick && (cnt <= 32'h00000001);
            if (!p.enable) begin
                cnt <= 32'h00000000;
            end else if (p.tick) begin
                if (cnt <= 32'h00000001) begin
                    cnt <= p.divisor;
                end else begin
                    cnt <= cnt - 32'h00000001;
                end
            end
        end
    end

    chk_div_reload: assert property (@(posedge clk) disable iff (!nrst)
        p.ce && p.enable && p.tick && cnt == 32'h00000001 |=> pulse && cnt == $past(p.divisor))
        else $error("divider did not reload and pulse at terminal count");

endmodule // cpt_divider

// [verilog/cpt_edge_sync.sv]
`timescale 1ns/1ps
module cpt_edge_sync #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // asynchronous pins in, clean levels and edges out
    input wire logic [W-1:0] din,
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic s1;
            logic s2;
            logic s3;
            // s1 is read by s2 only
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                end else if (ce) begin
                    s1 <= din[i];
                    s2 <= s1;
                    s3 <= s2;
                end
            end
            assign level[i] = s2;
            assign rise[i] = s2 & ~s3;
            assign fall[i] = ~s2 & s3;
        end
    endgenerate

endmodule // cpt_edge_sync

// [verilog/cpt_top.sv]
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "cpt_defines.svh"
// Contract
// - ai pacing divides 100 MHz base, rising edge
// - ai pacing rate 0.024 S/s to 500 KS/s
// - software picks ai pacing source and rate
// - external ai pacing converts on pin rising edge
// - ttl trigger zero/one selected edge raises event
// - threshold crossing up or down raises event
// - 16-bit threshold code written by software
// - ao update clock divides 100MHz by 32 bits
// - ao update rate capped at 3.030303 MS/s
// - external ao clock rising edge updates outputs
// - ttl trigger edge can start continuous output
// - ao trigger polarity rising or falling selectable
// - four ai trigger modes, start stop, delayed
// - 24 digital lines, each input or output
module cpt_top
    import cpt_pkg::*;
#(
    parameter int DIO_W = 24
) (
    // clock, reset, clock enable
    input wire logic CLK,
    input wire logic NRST,
    input wire logic CE,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // pacing and trigger pins
    input wire logic INPUT_PACING_CLOCK_PIN,
    input wire logic OUTPUT_PACING_CLOCK_PIN,
    input wire logic TTL_TRIGGER_IN_ZERO,
    input wire logic TTL_TRIGGER_IN_ONE,
    input wire logic THRESHOLD_TRIGGER_IN_ZERO,
    input wire logic THRESHOLD_TRIGGER_IN_ONE,
    input wire logic OUTPUT_TTL_TRIGGER_IN,
    // converter strobes and threshold dac code
    output logic AI_CONV_START,
    output logic AO_UPDATE,
    output logic [15:0] THRESH_CODE,
    // general purpose digital lines
    input wire logic [DIO_W-1:0] DIO_IN,
    output logic [DIO_W-1:0] DIO_OUT,
    output logic [DIO_W-1:0] DIO_OE
);
    localparam int PIN_W = `CPT_PIN_DIO + DIO_W;

    logic [31:0] ctrl;
    logic [31:0] ai_div;
    logic [31:0] ao_div;
    logic [31:0] delay;
    logic [31:0] dcnt;
    logic [8:0] tb_acc;
    logic tb_tick;
    logic [PIN_W-1:0] pins;
    logic [PIN_W-1:0] pin_lvl;
    logic [PIN_W-1:0] pin_rise;
    logic [PIN_W-1:0] pin_fall;
    logic [31:0] rdata;
    logic rhit;
    cpt_ai_state_e ai_state;
    cpt_ao_state_e ao_state;
    cpt_trig_mode_e ai_mode;

    // ---------------- apb access
    wire apb_acc = PSEL && PENABLE && !PREADY;
    wire apb_done = PSEL && PENABLE && PREADY;
    wire wr = apb_done && PWRITE;

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h00000000;
            PSLVERR <= 1'b0;
        end else if (CE) begin
            PREADY <= apb_acc;
            if (apb_acc) begin
                PRDATA <= PWRITE ? 32'h00000000 : rdata;
                PSLVERR <= !rhit;
            end else begin
                PSLVERR <= 1'b0;
            end
        end
    end

    // divisors clamped into the legal pacing range
    wire [31:0] ai_div_w = (PWDATA < `CPT_AI_MIN_DIV) ? `CPT_AI_MIN_DIV :
                           (PWDATA > `CPT_AI_MAX_DIV) ? `CPT_AI_MAX_DIV : PWDATA;
    wire [31:0] ao_div_w = (PWDATA < `CPT_AO_MIN_DIV) ? `CPT_AO_MIN_DIV : PWDATA;

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl <= `CPT_CTRL_RST;
            ai_div <= `CPT_AI_DIV_RST;
            ao_div <= `CPT_AO_DIV_RST;
            THRESH_CODE <= `CPT_THRESH_RST;
            delay <= `CPT_DELAY_RST;
            DIO_OE <= '0;
            DIO_OUT <= '0;
        end else if (CE && wr) begin
            case (PADDR)
                `CPT_OFF_CTRL: ctrl <= PWDATA;
                `CPT_OFF_AI_DIV: ai_div <= ai_div_w;
                `CPT_OFF_AO_DIV: ao_div <= ao_div_w;
                `CPT_OFF_THRESH: THRESH_CODE <= PWDATA[15:0];
                `CPT_OFF_DELAY: delay <= PWDATA;
                `CPT_OFF_DIO_DIR: DIO_OE <= PWDATA[DIO_W-1:0];
                `CPT_OFF_DIO_OUT: DIO_OUT <= PWDATA[DIO_W-1:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        rdata = 32'h00000000;
        rhit = 1'b1;
        case (PADDR)
            `CPT_OFF_CTRL: rdata = ctrl;
            `CPT_OFF_AI_DIV: rdata = ai_div;
            `CPT_OFF_AO_DIV: rdata = ao_div;
            `CPT_OFF_THRESH: rdata[15:0] = THRESH_CODE;
            `CPT_OFF_DELAY: rdata = delay;
            `CPT_OFF_DIO_DIR: rdata[DIO_W-1:0] = DIO_OE;
            `CPT_OFF_DIO_OUT: rdata[DIO_W-1:0] = DIO_OUT;
            `CPT_OFF_DIO_IN: rdata[DIO_W-1:0] = pin_lvl[PIN_W-1:`CPT_PIN_DIO];
            `CPT_OFF_STATUS: begin
                rdata[`CPT_STAT_AI_RUN] = (ai_state == AI_RUN) || (ai_state == AI_POST_DELAY);
                rdata[`CPT_STAT_AO_RUN] = (ao_state == AO_RUN);
                rdata[`CPT_STAT_AI_ARMED] = (ai_state == AI_ARMED) || (ai_state == AI_PRE_DELAY);
                rdata[`CPT_STAT_AI_DONE] = (ai_state == AI_DONE);
                rdata[`CPT_STAT_AO_ARMED] = (ao_state == AO_ARMED);
            end
            default: rhit = 1'b0;
        endcase
    end

    // ---------------- 100 MHz time base from the 250 MHz clock
    wire [9:0] tb_sum = {1'b0, tb_acc} + 10'(`CPT_TIMEBASE_MHZ);

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            tb_acc <= 9'h000;
            tb_tick <= 1'b0;
        end else if (CE) begin
            if (tb_sum >= 10'(`CPT_SYS_CLK_MHZ)) begin
                tb_acc <= 9'(tb_sum - 10'(`CPT_SYS_CLK_MHZ));
                tb_tick <= 1'b1;
            end else begin
                tb_acc <= tb_sum[8:0];
                tb_tick <= 1'b0;
            end
        end
    end

    // ---------------- pin synchronisers and edge detect
    assign pins = {DIO_IN, OUTPUT_TTL_TRIGGER_IN, THRESHOLD_TRIGGER_IN_ONE, THRESHOLD_TRIGGER_IN_ZERO,
                   TTL_TRIGGER_IN_ONE, TTL_TRIGGER_IN_ZERO, OUTPUT_PACING_CLOCK_PIN, INPUT_PACING_CLOCK_PIN};

    cpt_edge_sync #(.W(PIN_W)) u_sync (
        .clk(CLK),
        .nrst(NRST),
        .ce(CE),
        .din(pins),
        .level(pin_lvl),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    // ---------------- pacing dividers
    wire ai_en = ctrl[`CPT_CTRL_AI_EN];
    wire ai_ext = ctrl[`CPT_CTRL_AI_EXT];
    wire ao_en = ctrl[`CPT_CTRL_AO_EN];
    wire ao_ext = ctrl[`CPT_CTRL_AO_EXT];

    cpt_pace_if ai_if ();
    cpt_pace_if ao_if ();

    assign ai_if.ce = CE;
    assign ai_if.tick = tb_tick;
    assign ai_if.enable = ai_en && !ai_ext;
    assign ai_if.divisor = ai_div;
    assign ao_if.ce = CE;
    assign ao_if.tick = tb_tick;
    assign ao_if.enable = ao_en && !ao_ext;
    assign ao_if.divisor = ao_div;

    cpt_divider u_ai_div (
        .clk(CLK),
        .nrst(NRST),
        .p(ai_if.div)
    );

    cpt_divider u_ao_div (
        .clk(CLK),
        .nrst(NRST),
        .p(ao_if.div)
    );

    wire ai_pace = ai_ext ? pin_rise[`CPT_PIN_AI_PACE] : ai_if.pulse;
    wire ao_pace = ao_ext ? pin_rise[`CPT_PIN_AO_CLK] : ao_if.pulse;

    // ---------------- trigger events
    wire ai_fall = ctrl[`CPT_CTRL_AI_FALL];
    wire [1:0] ttl_edge = ai_fall ? pin_fall[`CPT_PIN_TTL1:`CPT_PIN_TTL0] : pin_rise[`CPT_PIN_TTL1:`CPT_PIN_TTL0];
    wire [1:0] thr_edge = ai_fall ? pin_fall[`CPT_PIN_THR1:`CPT_PIN_THR0] : pin_rise[`CPT_PIN_THR1:`CPT_PIN_THR0];
    wire ai_trig = ctrl[`CPT_CTRL_AI_ANALOG] ? |thr_edge : |ttl_edge;
    wire ao_trig = ctrl[`CPT_CTRL_AO_FALL] ? pin_fall[`CPT_PIN_AO_TRG] : pin_rise[`CPT_PIN_AO_TRG];

    assign ai_mode = cpt_trig_mode_e'(ctrl[`CPT_CTRL_AI_MODE_MSB:`CPT_CTRL_AI_MODE_LSB]);

    // ---------------- ai trigger sequencer, delay counted in pacing clocks
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ai_state <= AI_IDLE;
            dcnt <= 32'h00000000;
        end else if (CE) begin
            if (!ai_en) begin
                ai_state <= AI_IDLE;
            end else begin
                case (ai_state)
                    AI_IDLE: begin
                        if (ai_mode == CPT_TRG_START || ai_mode == CPT_TRG_DELAY_START) begin
                            ai_state <= AI_ARMED;
                        end else begin
                            ai_state <= AI_RUN;
                        end
                    end
                    AI_ARMED: begin
                        if (ai_trig) begin
                            dcnt <= delay;
                            ai_state <= (ai_mode == CPT_TRG_DELAY_START) ? AI_PRE_DELAY : AI_RUN;
                        end
                    end
                    AI_PRE_DELAY: begin
                        if (dcnt == 32'h00000000) begin
                            ai_state <= AI_RUN;
                        end else if (ai_pace) begin
                            dcnt <= dcnt - 32'h00000001;
                        end
                    end
                    AI_RUN: begin
                        if (ai_trig && ai_mode == CPT_TRG_STOP) begin
                            ai_state <= AI_DONE;
                        end else if (ai_trig && ai_mode == CPT_TRG_DELAY_STOP) begin
                            dcnt <= delay;
                            ai_state <= AI_POST_DELAY;
                        end
                    end
                    AI_POST_DELAY: begin
                        if (dcnt == 32'h00000000) begin
                            ai_state <= AI_DONE;
                        end else if (ai_pace) begin
                            dcnt <= dcnt - 32'h00000001;
                        end
                    end
                    AI_DONE: ai_state <= AI_DONE;
                    default: ai_state <= AI_IDLE;
                endcase
            end
        end
    end

    // ---------------- ao start sequencer
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ao_state <= AO_IDLE;
        end else if (CE) begin
            if (!ao_en) begin
                ao_state <= AO_IDLE;
            end else begin
                case (ao_state)
                    AO_IDLE: ao_state <= ctrl[`CPT_CTRL_AO_WAIT] ? AO_ARMED : AO_RUN;
                    AO_ARMED: begin
                        if (ao_trig) begin
                            ao_state <= AO_RUN;
                        end
                    end
                    AO_RUN: ao_state <= AO_RUN;
                    default: ao_state <= AO_IDLE;
                endcase
            end
        end
    end

    // ---------------- converter strobes
    wire ai_running = (ai_state == AI_RUN) || (ai_state == AI_POST_DELAY);

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            AI_CONV_START <= 1'b0;
            AO_UPDATE <= 1'b0;
        end else if (CE) begin
            AI_CONV_START <= ai_pace && ai_running;
            AO_UPDATE <= ao_pace && (ao_state == AO_RUN);
        end
    end

    // ---------------- checks
    chk_ai_div_range: assert property (@(posedge CLK) disable iff (!NRST)
        ai_div >= `CPT_AI_MIN_DIV && ai_div <= `CPT_AI_MAX_DIV)
        else $error("ai divisor outside legal pacing range");

    chk_ao_div_min: assert property (@(posedge CLK) disable iff (!NRST)
        ao_div >= `CPT_AO_MIN_DIV)
        else $error("ao divisor allows a rate above the maximum");

    chk_ai_ext_edge: assert property (@(posedge CLK) disable iff (!NRST)
        CE && ai_ext && ai_running && pin_rise[`CPT_PIN_AI_PACE] |=> AI_CONV_START)
        else $error("external ai pacing edge did not start a conversion");

    chk_ai_int_gate: assert property (@(posedge CLK) disable iff (!NRST)
        CE && !ai_ext && !ai_if.pulse |=> !AI_CONV_START)
        else $error("internal ai conversion without a divider pulse");

    chk_dtrg_start: assert property (@(posedge CLK) disable iff (!NRST)
        CE && ai_en && ai_state == AI_ARMED && ai_mode == CPT_TRG_START && !ctrl[`CPT_CTRL_AI_ANALOG]
        && ttl_edge != 2'b00 |=> ai_state == AI_RUN)
        else $error("ttl trigger edge did not start acquisition");

    chk_atrg_stop: assert property (@(posedge CLK) disable iff (!NRST)
        CE && ai_en && ai_state == AI_RUN && ai_mode == CPT_TRG_STOP && ctrl[`CPT_CTRL_AI_ANALOG]
        && thr_edge != 2'b00 |=> ai_state == AI_DONE ##1 !AI_CONV_START)
        else $error("threshold crossing did not stop acquisition");

    chk_thresh_write: assert property (@(posedge CLK) disable iff (!NRST)
        CE && wr && PADDR == `CPT_OFF_THRESH |=> THRESH_CODE == $past(PWDATA[15:0]))
        else $error("threshold code not taken from software write");

    chk_ao_trig_start: assert property (@(posedge CLK) disable iff (!NRST)
        CE && ao_en && ao_state == AO_ARMED && ao_trig |=> ao_state == AO_RUN)
        else $error("ao trigger edge did not start output");

    chk_ao_ext_edge: assert property (@(posedge CLK) disable iff (!NRST)
        CE && ao_ext && ao_state == AO_RUN && pin_rise[`CPT_PIN_AO_CLK] |=> AO_UPDATE)
        else $error("external ao clock edge did not update outputs");

    chk_dio_dir: assert property (@(posedge CLK) disable iff (!NRST)
        CE && wr && PADDR == `CPT_OFF_DIO_DIR |=> DIO_OE == $past(PWDATA[DIO_W-1:0]))
        else $error("digital line direction not taken from write");

    chk_apb_wait: assert property (@(posedge CLK) disable iff (!NRST)
        CE && apb_acc |=> PREADY ##1 !PREADY)
        else $error("apb ready not raised after one wait cycle");

endmodule // cpt_top

// [sim/cpt_pin_src.sv]
`timescale 1ns/1ps
module cpt_pin_src (
    // clock
    input wire logic clk,
    // pacing clocks, ttl and threshold trigger pins
    output logic [6:0] pins
);
    initial pins = 7'h00;

    // level held 80 ns so the synchroniser sees it
    task automatic set_pin(input int idx, input logic v);
        @(posedge clk);
        pins[idx] <= v;
        repeat (20) @(posedge clk);
    endtask

    // burst of pacing edges, clock stands low between bursts
    task automatic pace(input int idx, input int n, input int half);
        repeat (n) begin
            @(posedge clk);
            pins[idx] <= 1'b1;
            repeat (half) @(posedge clk);
            pins[idx] <= 1'b0;
            repeat (half) @(posedge clk);
        end
    endtask
endmodule // cpt_pin_src

// [sim/test_converter_pacing_and_trigger.sv]
`timescale 1ns/1ps
module test_converter_pacing_and_trigger;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ai_conv;
    logic ao_upd;
    logic [15:0] thresh;
    logic [23:0] dio_out;
    logic [23:0] dio_oe;
    logic [6:0] pins;
    logic [31:0] q;
    logic qerr;
    int num_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int ai_cnt = 0;
    int ao_cnt = 0;
    int ai_last = 0;
    int ai_gap = 0;

    always #2 clk = ~clk;

    // strobe counters and spacing of conversion starts
    always @(posedge clk) begin
        cyc++;
        if (ai_conv === 1'b1) begin
            ai_cnt++;
            ai_gap = cyc - ai_last;
            ai_last = cyc;
        end
        if (ao_upd === 1'b1) begin
            ao_cnt++;
        end
    end

    cpt_pin_src i_src (.clk(clk), .pins(pins));

    cpt_top i_dut (
        .CLK(clk), .NRST(nrst), .CE(1'b1),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .INPUT_PACING_CLOCK_PIN(pins[0]), .OUTPUT_PACING_CLOCK_PIN(pins[1]),
        .TTL_TRIGGER_IN_ZERO(pins[2]), .TTL_TRIGGER_IN_ONE(pins[3]),
        .THRESHOLD_TRIGGER_IN_ZERO(pins[4]), .THRESHOLD_TRIGGER_IN_ONE(pins[5]),
        .OUTPUT_TTL_TRIGGER_IN(pins[6]), .AI_CONV_START(ai_conv), .AO_UPDATE(ao_upd),
        .THRESH_CODE(thresh), .DIO_IN(24'h3c3c3c), .DIO_OUT(dio_out), .DIO_OE(dio_oe)
    );

    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40) begin
            num_errors++;
            end_of_test();
        end
        q = prdata;
        qerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(q, exp);
        chk(qerr, 32'h00000000);
    endtask

    task automatic t_regs;
        rd(8'h04, 32'h000000c8);
        rd(8'h08, 32'h00000021);
        rd(8'h0c, 32'h00008000);
        apb(1'b1, 8'h04, 32'h0000000a);
        rd(8'h04, 32'h000000c8);
        apb(1'b1, 8'h04, 32'hffffffff);
        rd(8'h04, 32'hf85a49aa);
        apb(1'b1, 8'h08, 32'h00000005);
        rd(8'h08, 32'h00000021);
        apb(1'b1, 8'h0c, 32'h00001234);
        @(negedge clk);
        chk(thresh, 32'h00001234);
        apb(1'b1, 8'h14, 32'h00ff00ff);
        apb(1'b1, 8'h18, 32'h00a5a5a5);
        @(negedge clk);
        chk(dio_oe, 32'h00ff00ff);
        chk(dio_out, 32'h00a5a5a5);
        rd(8'h1c, 32'h003c3c3c);
        // unmapped offset reads zero with an error response
        apb(1'b0, 8'h24, 32'h00000000);
        chk(q, 32'h00000000);
        chk(qerr, 32'h00000001);
    endtask

    task automatic t_ai_int;
        apb(1'b1, 8'h04, 32'd250);
        apb(1'b1, 8'h00, 32'h00000009);
        repeat (1400) @(posedge clk);
        chk(ai_gap, 32'd625);
        repeat (630) @(posedge clk);
        chk(ai_gap, 32'd625);
        apb(1'b1, 8'h00, 32'h00000000);
    endtask

    task automatic t_ai_modes;
        int exp_n[4] = '{5, 3, 2, 4};
        logic [31:0] exp_s[4] = '{32'h1, 32'h1, 32'h8, 32'h8};
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, 8'h10, 32'h00000002);
            if (m[0]) begin
                i_src.set_pin(3, 1'b1);
            end
            apb(1'b1, 8'h00, {26'h0, m[0], 1'b0, m[1:0], 2'h3});
            #1 ai_cnt = 0;
            i_src.pace(0, 2, 13);
            i_src.set_pin(2 + m[0], !m[0]);
            i_src.set_pin(2 + m[0], m[0]);
            i_src.pace(0, 5, 13);
            repeat (10) @(posedge clk);
            chk(ai_cnt, exp_n[m]);
            apb(1'b0, 8'h20, 32'h00000000);
            chk(q & 32'h9, exp_s[m]);
            apb(1'b1, 8'h00, 32'h00000000);
            m = m + 0;
        end
    endtask

    task automatic t_ai_analog;
        for (int f = 0; f < 2; f++) begin
            if (f[0]) begin
                i_src.set_pin(5, 1'b1);
            end
            // rising start on input zero, falling stop on input one
            apb(1'b1, 8'h00, {26'h0, f[0], 1'b1, f[0], 3'b001});
            apb(1'b0, 8'h20, 32'h00000000);
            chk(q & 32'hd, f[0] ? 32'h1 : 32'h4);
            i_src.set_pin(4 + f, !f[0]);
            apb(1'b0, 8'h20, 32'h00000000);
            chk(q & 32'hd, f[0] ? 32'h8 : 32'h1);
            i_src.set_pin(4 + f, f[0]);
            apb(1'b1, 8'h00, 32'h00000000);
        end
    endtask

    task automatic t_ao;
        apb(1'b1, 8'h00, 32'h00000500);
        apb(1'b0, 8'h20, 32'h00000000);
        chk(q & 32'h12, 32'h10);
        i_src.set_pin(6, 1'b1);
        #1 ao_cnt = 0;
        repeat (825) @(posedge clk);
        @(negedge clk);
        chk(ao_cnt, 32'd10);
        apb(1'b1, 8'h00, 32'h00000000);
        i_src.set_pin(6, 1'b1);
        apb(1'b1, 8'h00, 32'h00000f00);
        #1 ao_cnt = 0;
        i_src.pace(1, 2, 45);
        apb(1'b0, 8'h20, 32'h00000000);
        chk(q & 32'h12, 32'h10);
        i_src.set_pin(6, 1'b0);
        i_src.pace(1, 3, 45);
        repeat (10) @(posedge clk);
        chk(ao_cnt, 32'd3);
        apb(1'b1, 8'h00, 32'h00000000);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        chk(thresh, 32'h00008000);
        chk(ai_conv, 32'h0);
        nrst <= 1'b1;
        t_regs();
        t_ai_int();
        t_ai_modes();
        t_ai_analog();
        t_ao();
        end_of_test();
    end
endmodule // test_converter_pacing_and_trigger
